// >>> rtl/mss_device.sv
`timescale 1ns/1ps
// Behaviour
// - off or sleep command starts shutdown routine
// - reply OK while shutdown still running
// - routine end: pins tristated, supply output low
// - stay off until power-on request low
// - supply loss while off: not powered
// - host keeps supply until supply output low
// - host watches supply output fall as end
// - reboot command saves, detaches, then restarts
// - reset pulse restarts at once, no save
// - reset input pulled high internally
// - reset hits core only, not power unit
// - host drives reset low on supply failure
// - host prefers reset pin to supply removal
// - host holds power-on request low to wake
module mss_device
	import mss_pkg::*;
#(
	parameter int unsigned SAVE_CYC    = SAVE_CYC_DEF,
	parameter int unsigned DETACH_CYC  = DETACH_CYC_DEF,
	parameter int unsigned BOOT_CYC    = BOOT_CYC_DEF,
	parameter int unsigned RESET_CYC   = RESET_MIN_CYC,
	parameter int unsigned PWRON_CYC   = PWRON_MIN_CYC
) (
	input  wire logic           i_clock,
	input  wire logic           i_rst_n,
	mss_link_if.dev             link,
	output logic                o_core_reset,
	output logic                o_nv_store,
	output logic                o_net_detach,
	output logic [3:0]          o_mode
);
	import mss_pkg::*;

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_UNPOWERED = 7'h01,
		ST_BOOT      = 7'h02,
		ST_ACTIVE    = 7'h04,
		ST_SAVE      = 7'h08,
		ST_DETACH    = 7'h10,
		ST_OFF       = 7'h20,
		ST_CORE_RST  = 7'h40
	} mss_state_e;

	mss_state_e state;
	mss_state_e next_state;
	logic       restart;
	logic       next_restart;
	logic       rsp_valid;
	logic       next_rsp_valid;
	logic [1:0] rsp_code;
	logic [1:0] next_rsp_code;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic       pwron_n_s;
	logic       reset_n_s;
	logic       vcc_s;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			sync1 <= 3'h7;
			sync2 <= 3'h7;
		end else begin
			sync1 <= {link.vcc_present, link.reset_line, link.power_on_request_n};
			sync2 <= sync1;
		end
	end

	assign pwron_n_s = sync2[0];
	assign reset_n_s = sync2[1];
	assign vcc_s     = sync2[2];

	// ----------------------------------------------------------------
	// low-level width filters
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] rst_low;
	logic [CNT_W-1:0] next_rst_low;
	logic [CNT_W-1:0] pwr_low;
	logic [CNT_W-1:0] next_pwr_low;
	logic             rst_valid;
	logic             pwr_valid;

	always_comb begin
		next_rst_low = reset_n_s ? '0 : ((rst_low == CNT_W'(RESET_CYC)) ? rst_low : rst_low + CNT_W'(1));
		next_pwr_low = pwron_n_s ? '0 : ((pwr_low == CNT_W'(PWRON_CYC)) ? pwr_low : pwr_low + CNT_W'(1));
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rst_low <= '0;
			pwr_low <= '0;
		end else begin
			rst_low <= next_rst_low;
			pwr_low <= next_pwr_low;
		end
	end

	assign rst_valid = (rst_low == CNT_W'(RESET_CYC));
	assign pwr_valid = (pwr_low == CNT_W'(PWRON_CYC));

	// ----------------------------------------------------------------
	// phase timer
	// ----------------------------------------------------------------
	logic             t_load;
	logic [CNT_W-1:0] t_value;
	logic             t_busy;
	logic             t_done;

	mss_pulse_count #(
		.W       (CNT_W)
	) u_timer (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_load  (t_load),
		.i_value (t_value),
		.o_busy  (t_busy),
		.o_done  (t_done)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state     = state;
		next_restart   = restart;
		next_rsp_valid = 1'b0;
		next_rsp_code  = rsp_code;
		t_load         = 1'b0;
		t_value        = '0;
		case (state)
			ST_UNPOWERED: begin
				if (vcc_s && pwr_valid) begin
					next_state = ST_BOOT;
					t_load     = 1'b1;
					t_value    = CNT_W'(BOOT_CYC);
				end
			end
			ST_BOOT: begin
				if (t_done) begin
					next_state   = ST_ACTIVE;
					// restart only marks a reboot still in flight
					next_restart = 1'b0;
				end
			end
			ST_ACTIVE: begin
				if (link.cmd_valid) begin
					next_rsp_valid = 1'b1;
					next_rsp_code  = RSP_OK;
					if (link.cmd_code == CMD_POWEROFF || link.cmd_code == CMD_SLEEPOFF) begin
						next_state   = ST_SAVE;
						next_restart = 1'b0;
						t_load       = 1'b1;
						t_value      = CNT_W'(SAVE_CYC);
					end else if (link.cmd_code == CMD_REBOOT ||
						     link.cmd_code == CMD_ALTBOOT) begin
						next_state   = ST_SAVE;
						next_restart = 1'b1;
						t_load       = 1'b1;
						t_value      = CNT_W'(SAVE_CYC);
					end else begin
						next_rsp_code = RSP_ERROR;
					end
				end
			end
			ST_SAVE: begin
				if (t_done) begin
					next_state = ST_DETACH;
					t_load     = 1'b1;
					t_value    = CNT_W'(DETACH_CYC);
				end
			end
			ST_DETACH: begin
				if (t_done) begin
					t_load  = restart;
					t_value = CNT_W'(BOOT_CYC);
					next_state = restart ? ST_BOOT : ST_OFF;
				end
			end
			ST_OFF: begin
				if (!vcc_s) begin
					next_state = ST_UNPOWERED;
				end else if (pwr_valid) begin
					next_state = ST_BOOT;
					t_load     = 1'b1;
					t_value    = CNT_W'(BOOT_CYC);
				end
			end
			ST_CORE_RST: begin
				if (reset_n_s) begin
					next_state = ST_BOOT;
					t_load     = 1'b1;
					t_value    = CNT_W'(BOOT_CYC);
				end
			end
			default: next_state = ST_UNPOWERED;
		endcase
		// reset pin restarts the core with no save or detach
		if (rst_valid && state != ST_OFF && state != ST_UNPOWERED) begin
			next_state     = ST_CORE_RST;
			next_rsp_valid = 1'b0;
		end
		if (!vcc_s) begin
			next_state     = ST_UNPOWERED;
			next_rsp_valid = 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state     <= ST_UNPOWERED;
			restart   <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_code  <= RSP_OK;
		end else begin
			state     <= next_state;
			restart   <= next_restart;
			rsp_valid <= next_rsp_valid;
			rsp_code  <= next_rsp_code;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	logic powered;
	assign powered = (state != ST_OFF) && (state != ST_UNPOWERED);

	// interface supply stays up through a core reset, power unit untouched
	assign link.v_int     = powered;
	assign link.rsp_valid = rsp_valid;
	assign link.rsp_code  = rsp_code;

	genvar g;
	generate
		for (g = 0; g < PIN_W; g++) begin : g_pin
			assign link.pin_o[g]  = 1'b0;
			assign link.pin_oe[g] = ~(state == ST_ACTIVE);
		end
	endgenerate

	assign o_core_reset = (state == ST_CORE_RST) || (state == ST_BOOT);
	assign o_nv_store   = (state == ST_SAVE);
	assign o_net_detach = (state == ST_DETACH);
	assign o_mode       = {restart, state[5], state[2], state[0]};
endmodule

// >>> rtl/mss_host.sv
`timescale 1ns/1ps
module mss_host
	import mss_pkg::*;
#(
	parameter int unsigned RESET_CYC = RESET_MIN_CYC,
	parameter int unsigned PWRON_CYC = PWRON_MIN_CYC
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	mss_link_if.host              link,
	input  wire logic             i_send,
	input  wire logic [CMD_W-1:0] i_cmd,
	input  wire logic             i_wake,
	input  wire logic             i_hard_reset,
	input  wire logic             i_supply_fail,
	input  wire logic             i_supply_off_req,
	output logic                  o_busy,
	output logic                  o_got_ok,
	output logic                  o_shutdown_done
);
	import mss_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [1:0]       vint_sync;
	logic             vint_prev;
	logic             shutting;
	logic             next_shutting;
	logic             vcc;
	logic             next_vcc;
	logic [CNT_W-1:0] rst_cnt;
	logic [CNT_W-1:0] next_rst_cnt;
	logic [CNT_W-1:0] pwr_cnt;
	logic [CNT_W-1:0] next_pwr_cnt;
	logic             got_ok;
	logic             next_got_ok;
	logic             done;
	logic             next_done;
	logic             fail_hold;
	logic             next_fail_hold;

	always_comb begin
		next_shutting  = shutting;
		next_vcc       = vcc;
		next_rst_cnt   = (rst_cnt != '0) ? rst_cnt - CNT_W'(1) : rst_cnt;
		next_pwr_cnt   = (pwr_cnt != '0) ? pwr_cnt - CNT_W'(1) : pwr_cnt;
		next_got_ok    = link.rsp_valid && link.rsp_code == RSP_OK;
		next_done      = 1'b0;
		next_fail_hold = fail_hold | i_supply_fail;
		if (i_send && (i_cmd == CMD_POWEROFF || i_cmd == CMD_SLEEPOFF)) begin
			next_shutting = 1'b1;
		end
		// fall of the interface supply ends the shutdown
		if (shutting && vint_prev && !vint_sync[1]) begin
			next_shutting = 1'b0;
			next_done     = 1'b1;
		end
		// supply removed only once the interface supply is low
		if (i_supply_off_req && !vint_sync[1]) begin
			next_vcc = 1'b0;
		end
		if (i_wake) begin
			next_vcc     = 1'b1;
			next_pwr_cnt = CNT_W'(PWRON_CYC);
		end
		if (i_hard_reset) begin
			next_rst_cnt = CNT_W'(RESET_CYC);
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			vint_sync <= 2'h0;
			vint_prev <= 1'b0;
			shutting  <= 1'b0;
			vcc       <= 1'b1;
			rst_cnt   <= '0;
			pwr_cnt   <= '0;
			got_ok    <= 1'b0;
			done      <= 1'b0;
			fail_hold <= 1'b0;
		end else begin
			vint_sync <= {vint_sync[0], link.v_int};
			vint_prev <= vint_sync[1];
			shutting  <= next_shutting;
			vcc       <= next_vcc;
			rst_cnt   <= next_rst_cnt;
			pwr_cnt   <= next_pwr_cnt;
			got_ok    <= next_got_ok;
			done      <= next_done;
			fail_hold <= next_fail_hold;
		end
	end

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	assign link.cmd_valid          = i_send;
	assign link.cmd_code           = i_cmd;
	assign link.vcc_present        = vcc;
	assign link.power_on_request_n = (pwr_cnt == '0);
	assign link.reset_n_o          = 1'b0;
	// supply failure holds reset low until the host reset clears it
	assign link.reset_n_oe         = ~((rst_cnt != '0) || fail_hold);

	assign o_busy          = shutting || (rst_cnt != '0) || (pwr_cnt != '0);
	assign o_got_ok        = got_ok;
	assign o_shutdown_done = done;
endmodule

// >>> rtl/mss_link_if.sv
`timescale 1ns/1ps
interface mss_link_if;
	import mss_pkg::*;
	logic             cmd_valid;
	logic [CMD_W-1:0] cmd_code;
	logic             rsp_valid;
	logic [1:0]       rsp_code;
	logic             power_on_request_n;
	logic             reset_n_o;
	logic             reset_n_oe;
	logic             vcc_present;
	logic             v_int;
	logic [PIN_W-1:0] pin_o;
	logic [PIN_W-1:0] pin_oe;
	// the device pull-up keeps the reset line high unless the host drives it
	wire              reset_line = reset_n_oe ? 1'b1 : reset_n_o;
	modport dev (
		input  cmd_valid, cmd_code, power_on_request_n, reset_line, vcc_present,
		output rsp_valid, rsp_code, v_int, pin_o, pin_oe
	);
	modport host (
		output cmd_valid, cmd_code, power_on_request_n, reset_n_o, reset_n_oe, vcc_present,
		input  rsp_valid, rsp_code, v_int
	);
endinterface

// >>> rtl/mss_pkg.sv
package mss_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ            = 10_000_000;
	localparam int unsigned UVLO_SAFE_MS      = 405;
	localparam int unsigned UVLO_SAFE_CYC     = UVLO_SAFE_MS * (CLK_HZ / 1000);
	localparam int unsigned RESET_MIN_NS      = 1000;
	localparam int unsigned RESET_MIN_CYC     = (RESET_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned PWRON_MIN_NS      = 2000;
	localparam int unsigned PWRON_MIN_CYC     = (PWRON_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned SAVE_CYC_DEF      = 64;
	localparam int unsigned DETACH_CYC_DEF    = 32;
	localparam int unsigned BOOT_CYC_DEF      = 48;
	localparam int unsigned CNT_W             = 24;
	localparam int unsigned PIN_W             = 8;
	localparam int unsigned CMD_W             = 3;
	// ----------------------------------------------------------------
	// commands
	// ----------------------------------------------------------------
	localparam logic [2:0] CMD_NONE     = 3'h0;
	localparam logic [2:0] CMD_POWEROFF = 3'h1;
	localparam logic [2:0] CMD_SLEEPOFF = 3'h2;
	localparam logic [2:0] CMD_REBOOT   = 3'h3;
	localparam logic [2:0] CMD_ALTBOOT  = 3'h4;
	localparam logic [7:0] REBOOT_FUNC_LEVEL = 8'h10;
	// ----------------------------------------------------------------
	// response codes
	// ----------------------------------------------------------------
	localparam logic [1:0] RSP_OK    = 2'h0;
	localparam logic [1:0] RSP_ERROR = 2'h1;
endpackage

// >>> rtl/mss_pulse_count.sv
`timescale 1ns/1ps
module mss_pulse_count #(
	parameter int unsigned W = 24
) (
	input  wire logic         i_clock,
	input  wire logic         i_rst_n,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_value,
	output logic              o_busy,
	output logic              o_done
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic         done;
	logic         next_done;

	always_comb begin
		next_count = count;
		next_done  = 1'b0;
		if (i_load) begin
			next_count = i_value;
		end else if (count != '0) begin
			next_count = count - W'(1);
			next_done  = (count == W'(1));
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			count <= '0;
			done  <= 1'b0;
		end else begin
			count <= next_count;
			done  <= next_done;
		end
	end

	assign o_busy = (count != '0);
	assign o_done = done;
endmodule

// >>> testbench/module_shutdown_reset_sequencer_tb.sv
`timescale 1ns/1ps
module module_shutdown_reset_sequencer_tb;
	import mss_pkg::*;
	typedef struct packed {
		logic [2:0] cmd;
		logic [3:0] mode;
		logic [4:0] seen;
	} mss_row_s;
	logic             i_clock;
	logic             i_rst_n;
	logic             i_send;
	logic [CMD_W-1:0] i_cmd;
	logic             i_wake;
	logic             i_hard_reset;
	logic             i_supply_fail;
	logic             i_supply_off_req;
	logic             o_core_reset;
	logic             o_nv_store;
	logic             o_net_detach;
	logic [3:0]       o_mode;
	logic             o_shutdown_done;
	logic             o_got_ok;
	logic             o_busy;
	logic             clr;
	logic [4:0]       seen;
	int               num_errors;
	int               tests_run;
	// detach, done, error, ok, store
	mss_row_s         rows [4] = '{'{CMD_REBOOT, 4'h2, 5'h13}, '{CMD_ALTBOOT, 4'h2, 5'h13},
		'{CMD_POWEROFF, 4'h4, 5'h1B}, '{CMD_SLEEPOFF, 4'h4, 5'h1B}};
	mss_link_if link ();
	mss_device #(.SAVE_CYC(4), .DETACH_CYC(3), .BOOT_CYC(5), .RESET_CYC(2), .PWRON_CYC(2))
	mss_device_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .link(link),
		.o_core_reset(o_core_reset), .o_nv_store(o_nv_store), .o_net_detach(o_net_detach),
		.o_mode(o_mode));
	mss_host mss_host_inst (.i_clock(i_clock),
		.i_rst_n(i_rst_n), .link(link), .i_send(i_send), .i_cmd(i_cmd), .i_wake(i_wake),
		.i_hard_reset(i_hard_reset), .i_supply_fail(i_supply_fail),
		.i_supply_off_req(i_supply_off_req), .o_busy(o_busy), .o_got_ok(o_got_ok),
		.o_shutdown_done(o_shutdown_done));
	// checker timing defaults equal the device overrides above
	mss_properties mss_properties_inst (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .cmd_valid(link.cmd_valid),
		.cmd_code(link.cmd_code), .rsp_valid(link.rsp_valid), .rsp_code(link.rsp_code),
		.power_on_request_n(link.power_on_request_n), .reset_line(link.reset_line),
		.vcc_present(link.vcc_present), .v_int(link.v_int), .pin_oe(link.pin_oe));
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		seen <= clr ? 5'h00 : seen | {o_net_detach, o_shutdown_done,
			link.rsp_valid && link.rsp_code == RSP_ERROR, o_got_ok, o_nv_store};
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task tick(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask
	task test_done;
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one-cycle strobe: bit 0 send, 1 wake, 2 hard reset, 3 supply fail
	task pulse(input logic [3:0] m);
		{i_supply_fail, i_hard_reset, i_wake, i_send} <= m;
		tick(1);
		{i_supply_fail, i_hard_reset, i_wake, i_send} <= 4'h0;
		tick(1);
	endtask
	task send(input logic [2:0] c);
		i_cmd <= c;
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
		pulse(4'h1);
	endtask
	task wake;
		pulse(4'h2);
		tick(30);
		chk("wake mode", 8'h02, o_mode);
	endtask
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		{i_send, i_cmd, i_wake, i_hard_reset, i_supply_fail, i_supply_off_req, clr} = '0;
		num_errors = 0;
		tests_run = 0;
		i_rst_n = 1'b0;
		tick(6);
		i_rst_n <= 1'b1;
		tick(2);
		for (int i = 0; i < 4; i++) begin
			if (o_mode !== 4'h2)
				wake();
			send(rows[i].cmd);
			tick(40);
			chk("mode", rows[i].mode, o_mode);
			chk("events", rows[i].seen, seen);
		end
		send(CMD_POWEROFF);
		tick(10);
		chk("off ignores", 8'h00, seen);
		i_supply_off_req <= 1'b1;
		tick(5);
		chk("unpowered", 8'h01, o_mode);
		i_supply_off_req <= 1'b0;
		tick(3);
		wake();
		i_supply_off_req <= 1'b1;
		tick(5);
		chk("supply kept", 8'h01, link.vcc_present);
		send(CMD_POWEROFF);
		tick(40);
		chk("supply after off", 8'h01, o_mode);
		i_supply_off_req <= 1'b0;
		tick(3);
		wake();
		send(3'h5);
		tick(3);
		chk("bad code", 8'h04, seen);
		pulse(4'h4);
		tick(8);
		chk("reset supply", 8'h01, link.v_int);
		chk("core reset", 8'h01, o_core_reset);
		chk("host busy", 8'h01, o_busy);
		tick(40);
		chk("reset back", 8'h02, o_mode);
		chk("core running", 8'h00, o_core_reset);
		chk("host idle", 8'h00, o_busy);
		chk("reset no save", 8'h00, seen & 5'h11);
		pulse(4'h8);
		tick(8);
		chk("fail reset low", 8'h00, link.reset_line);
		i_rst_n <= 1'b0;
		tick(3);
		i_rst_n <= 1'b1;
		tick(2);
		chk("reset mode", 8'h01, o_mode);
		chk("reset pins", 8'hFF, link.pin_oe);
		test_done;
	end
	initial begin
		tick(3000);
		num_errors++;
		test_done;
	end
endmodule

// >>> testbench/mss_properties.sv
`timescale 1ns/1ps
module mss_properties
	import mss_pkg::*;
#(
	parameter int SAVE_CYC   = 4,
	parameter int DETACH_CYC = 3,
	parameter int BOOT_CYC   = 5
) (
	input wire logic             i_clock,
	input wire logic             i_rst_n,
	input wire logic             cmd_valid,
	input wire logic [CMD_W-1:0] cmd_code,
	input wire logic             rsp_valid,
	input wire logic [1:0]       rsp_code,
	input wire logic             power_on_request_n,
	input wire logic             reset_line,
	input wire logic             vcc_present,
	input wire logic             v_int,
	input wire logic [PIN_W-1:0] pin_oe
);
	localparam int OFF_LO = SAVE_CYC + DETACH_CYC + 1;
	localparam int OFF_HI = SAVE_CYC + DETACH_CYC + 4;
	localparam int RB_LO  = SAVE_CYC + DETACH_CYC + BOOT_CYC + 2;
	localparam int RB_HI  = SAVE_CYC + DETACH_CYC + BOOT_CYC + 5;
	wire ready = (pin_oe == '0) && vcc_present && reset_line;
	wire off_c = (cmd_code == CMD_POWEROFF) || (cmd_code == CMD_SLEEPOFF);
	wire rb_c  = (cmd_code == CMD_REBOOT) || (cmd_code == CMD_ALTBOOT);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// ----------------------------------------------------------------
	// command answers
	// ----------------------------------------------------------------
	a_ok_on_cmd: assert property (cmd_valid && ready && (off_c || rb_c) |=>
		rsp_valid && rsp_code == RSP_OK) else $error("no OK after command");
	a_err_bad_code: assert property (cmd_valid && ready && cmd_code > CMD_ALTBOOT |=>
		rsp_valid && rsp_code == RSP_ERROR) else $error("no error on bad code");
	a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer longer than one cycle");
	a_rsp_has_cause: assert property (rsp_valid |-> $past(cmd_valid))
		else $error("answer without command");
	// ----------------------------------------------------------------
	// shutdown and restart
	// ----------------------------------------------------------------
	a_off_ends_low: assert property (cmd_valid && ready && off_c && vcc_present |=>
		##[OFF_LO:OFF_HI] !v_int) else $error("supply output not low in time");
	a_pins_all_same: assert property (pin_oe == '0 || pin_oe == '1)
		else $error("pins partly driven");
	a_pins_off_low: assert property (!v_int |-> pin_oe == '1)
		else $error("pins driven while supply output low");
	a_stay_off: assert property ((!v_int && power_on_request_n && reset_line) [*4] |=>
		!v_int) else $error("woke without request");
	a_supply_loss: assert property (!vcc_present ##1 !vcc_present |->
		!v_int && pin_oe == '1) else $error("not unpowered after supply loss");
	a_reboot_back: assert property (cmd_valid && ready && rb_c |=>
		##[RB_LO:RB_HI] (pin_oe == '0 && v_int)) else $error("no return after reboot");
	a_reset_core: assert property ((!reset_line && vcc_present && v_int) [*8] |=>
		pin_oe == '1 && v_int) else $error("reset pin effect wrong");
endmodule
